// File: logic/odo_pkg.sv
// Constants and types for the operand data organization block
package odo_pkg;
   localparam int unsigned ODO_DATA_W      = 32;
   localparam int unsigned ODO_WORD_W      = 16;
   localparam int unsigned ODO_BYTE_W      = 8;
   localparam int unsigned ODO_NIBBLE_W    = 4;
   localparam int unsigned ODO_NUM_DREG    = 8;
   localparam int unsigned ODO_NUM_AREG    = 8;
   localparam int unsigned ODO_REG_IDX_W   = 3;
   localparam int unsigned ODO_BIT_IDX_W   = 5;
   localparam int unsigned ODO_ADDR_W      = 24;
   localparam logic [31:0] ODO_REG_RESET   = 32'h0000_0000;
   localparam logic [23:0] ODO_LONG_STEP   = 24'h00_0002;

   typedef enum logic [1:0] {
      ODO_SZ_BYTE = 2'b00,
      ODO_SZ_WORD = 2'b01,
      ODO_SZ_LONG = 2'b10,
      ODO_SZ_BIT  = 2'b11
   } odo_size_t;

   // How the operand register is located
   typedef enum logic [1:0] {
      ODO_LOC_FIELD    = 2'b00,
      ODO_LOC_EA       = 2'b01,
      ODO_LOC_IMPLIED  = 2'b10
   } odo_loc_t;

   typedef enum logic [1:0] {
      ODO_MS_IDLE  = 2'b00,
      ODO_MS_HI    = 2'b01,
      ODO_MS_LO    = 2'b10
   } odo_mstate_t;
endpackage : odo_pkg

// File: logic/odo_mem_port.sv
// Memory sequencer: byte lanes, alignment and long word split
`timescale 1ns/1ps
module odo_mem_port
   import odo_pkg::*;
(
   // Clock and reset
   input  wire logic                  clk_i,
   input  wire logic                  rst_i,
   // Request
   input  wire logic                  req_i,
   input  wire logic                  we_i,
   input  wire odo_size_t             size_i,
   input  wire logic [ODO_ADDR_W-1:0] addr_i,
   input  wire logic [31:0]           wdata_i,
   output logic                       busy_o,
   output logic                       done_o,
   output logic                       align_err_o,
   output logic [31:0]                rdata_o,
   // Word memory
   output logic                       mem_req_o,
   output logic                       mem_we_o,
   output logic [ODO_ADDR_W-1:0]      mem_addr_o,
   output logic [1:0]                 mem_be_o,
   output logic [15:0]                mem_wdata_o,
   input  wire logic [15:0]           mem_rdata_i
);
   odo_mstate_t           state, next_state;
   logic [ODO_ADDR_W-1:0] addr, next_addr;
   logic [31:0]           wdata, next_wdata, rdata, next_rdata;
   logic                  we, next_we, done, next_done, aerr, next_aerr;
   odo_size_t             size, next_size;
   logic                  mreq, next_mreq;

   always_comb begin
      next_state = state;
      next_addr  = addr;
      next_wdata = wdata;
      next_rdata = rdata;
      next_we    = we;
      next_size  = size;
      next_done  = 1'b0;
      next_aerr  = 1'b0;
      next_mreq  = 1'b0;
      unique case (state)
         ODO_MS_IDLE: begin
            if (req_i) begin
               // Odd address only legal for a byte
               if (addr_i[0] && size_i != ODO_SZ_BYTE) begin
                  next_aerr = 1'b1;
                  next_done = 1'b1;
               end else begin
                  next_addr  = addr_i;
                  next_wdata = wdata_i;
                  next_we    = we_i;
                  next_size  = size_i;
                  next_mreq  = 1'b1;
                  next_state = (size_i == ODO_SZ_LONG) ? ODO_MS_HI : ODO_MS_LO;
               end
            end
         end
         ODO_MS_HI: begin
            // High word at n, low word at n+2
            next_rdata[31:16] = mem_rdata_i;
            next_addr         = addr + ODO_LONG_STEP;
            next_mreq         = 1'b1;
            next_state        = ODO_MS_LO;
         end
         ODO_MS_LO: begin
            if (size == ODO_SZ_LONG) begin
               next_rdata[15:0] = mem_rdata_i;
            end else if (size == ODO_SZ_WORD) begin
               next_rdata = {16'h0000, mem_rdata_i};
            end else begin
               // Even byte is the high half
               next_rdata = {24'h00_0000,
                             addr[0] ? mem_rdata_i[7:0] : mem_rdata_i[15:8]};
            end
            next_done  = 1'b1;
            next_state = ODO_MS_IDLE;
         end
         default: next_state = ODO_MS_IDLE;
      endcase
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state <= ODO_MS_IDLE;
         addr  <= '0;
         wdata <= ODO_REG_RESET;
         rdata <= ODO_REG_RESET;
         we    <= 1'b0;
         size  <= ODO_SZ_BYTE;
         done  <= 1'b0;
         aerr  <= 1'b0;
         mreq  <= 1'b0;
      end else begin
         state <= next_state;
         addr  <= next_addr;
         wdata <= next_wdata;
         rdata <= next_rdata;
         we    <= next_we;
         size  <= next_size;
         done  <= next_done;
         aerr  <= next_aerr;
         mreq  <= next_mreq;
      end
   end

   assign busy_o      = (state != ODO_MS_IDLE);
   assign done_o      = done;
   assign align_err_o = aerr;
   assign rdata_o     = rdata;
   assign mem_req_o   = mreq;
   assign mem_we_o    = we & mreq;
   // Word address always even on the memory side
   assign mem_addr_o  = {addr[ODO_ADDR_W-1:1], 1'b0};
   assign mem_be_o    = (size == ODO_SZ_BYTE) ? (addr[0] ? 2'b01 : 2'b10) : 2'b11;
   always_comb begin
      if (size == ODO_SZ_LONG) begin
         mem_wdata_o = (state == ODO_MS_HI) ? wdata[31:16] : wdata[15:0];
      end else if (size == ODO_SZ_BYTE) begin
         mem_wdata_o = {wdata[7:0], wdata[7:0]};
      end else begin
         mem_wdata_o = wdata[15:0];
      end
   end

   AST_ALIGN_ODD: assert property (@(posedge clk_i) disable iff (rst_i)
      req_i && !busy_o && addr_i[0] && size_i != ODO_SZ_BYTE |=> align_err_o && !mem_req_o)
      else $error("misaligned multibyte access not refused");
   AST_LONG_STEP: assert property (@(posedge clk_i) disable iff (rst_i)
      mem_req_o && state == ODO_MS_HI |=> mem_req_o && mem_addr_o == $past(mem_addr_o) + 24'h2)
      else $error("second word of long not at n+2");
   AST_MEM_EVEN: assert property (@(posedge clk_i) disable iff (rst_i)
      mem_req_o |-> !mem_addr_o[0])
      else $error("memory word address odd");
endmodule : odo_mem_port

// File: logic/odo_core.sv
// Operand data organization: data and address registers, BCD and memory
`timescale 1ns/1ps
// Behaviour
// - Byte is 8 bits, word is 16 bits, long word is 32 bits.
// - Size comes from instruction encoding or is implied; implied takes subset.
// - Data registers accept bit, byte, word and long operands.
// - Data register holds byte low 8, word low 16, long all 32.
// - Bit zero is least significant, bit 31 most significant.
// - Data register access uses and changes only the sized low portion.
// - Address registers and stack pointer are 32 bits, reject byte size.
// - Address register source gives low 16 bits for word, 32 for long.
// - Address register destination write updates all bits.
// - Word operation to address register sign-extends operands to 32 bits.
// - Bytes addressable; high byte at even address, low byte at odd.
// - Fetches and multibyte accesses only at even addresses.
// - Long at even n has its second word at n plus two.
// - Packed decimal stores two BCD digits per byte.
// - Operand located by register field, effective address, or implied register.
module odo_core
   import odo_pkg::*;
(
   // Clock and reset
   input  wire logic                     CLK_I,
   input  wire logic                     RST_I,
   // Operand size and location
   input  wire odo_size_t                SIZE_I,
   input  wire logic                     SIZE_EXPLICIT_I,
   input  wire logic [2:0]               SIZE_ALLOWED_I,
   input  wire odo_loc_t                 LOC_I,
   input  wire logic [ODO_REG_IDX_W-1:0] FIELD_REG_I,
   input  wire logic [ODO_REG_IDX_W-1:0] EA_REG_I,
   input  wire logic [ODO_REG_IDX_W-1:0] IMPL_REG_I,
   input  wire logic                     IS_ADDR_I,
   input  wire logic [ODO_BIT_IDX_W-1:0] BIT_NUM_I,
   // Register write
   input  wire logic                     WR_I,
   input  wire logic [31:0]              WDATA_I,
   // Register read
   output logic [31:0]                   RDATA_O,
   output logic                          RBIT_O,
   output logic                          SIZE_ERR_O,
   // Packed decimal
   input  wire logic [7:0]               BCD_BIN_I,
   output logic [7:0]                    BCD_PACK_O,
   output logic [3:0]                    BCD_HI_O,
   output logic [3:0]                    BCD_LO_O,
   // Memory request
   input  wire logic                     MREQ_I,
   input  wire logic                     MWE_I,
   input  wire logic [ODO_ADDR_W-1:0]    MADDR_I,
   output logic                          MBUSY_O,
   output logic                          MDONE_O,
   output logic                          MALIGN_ERR_O,
   output logic [31:0]                   MRDATA_O,
   // Word memory
   output logic                          MEM_REQ_O,
   output logic                          MEM_WE_O,
   output logic [ODO_ADDR_W-1:0]         MEM_ADDR_O,
   output logic [1:0]                    MEM_BE_O,
   output logic [15:0]                   MEM_WDATA_O,
   input  wire logic [15:0]              MEM_RDATA_I
);
   logic [31:0]              dreg [ODO_NUM_DREG];
   logic [31:0]              areg [ODO_NUM_AREG];
   logic [31:0]              next_dreg [ODO_NUM_DREG];
   logic [31:0]              next_areg [ODO_NUM_AREG];
   logic [ODO_REG_IDX_W-1:0] sel;
   logic                     size_ok;
   logic [31:0]              rd_raw;
   logic [31:0]              rdata, next_rdata;
   logic                     rbit, next_rbit, serr, next_serr;
   logic [7:0]               bcd, next_bcd;

   // Merge a sized value into the low portion of an old register value
   function automatic logic [31:0] odo_merge(input logic [31:0] old,
                                             input logic [31:0] val,
                                             input odo_size_t   sz);
      logic [31:0] r;
      r = old;
      unique case (sz)
         ODO_SZ_BYTE: r[ODO_BYTE_W-1:0] = val[ODO_BYTE_W-1:0];
         ODO_SZ_WORD: r[ODO_WORD_W-1:0] = val[ODO_WORD_W-1:0];
         ODO_SZ_LONG: r = val;
         ODO_SZ_BIT:  r = old;
      endcase
      return r;
   endfunction : odo_merge

   // Zero the bits above the operand size
   function automatic logic [31:0] odo_trim(input logic [31:0] val,
                                            input odo_size_t   sz);
      logic [31:0] r;
      unique case (sz)
         ODO_SZ_BYTE: r = {24'h00_0000, val[7:0]};
         ODO_SZ_WORD: r = {16'h0000, val[15:0]};
         ODO_SZ_LONG: r = val;
         ODO_SZ_BIT:  r = {31'h0000_0000, val[0]};
      endcase
      return r;
   endfunction : odo_trim

   // Operand register location
   always_comb begin
      unique case (LOC_I)
         ODO_LOC_FIELD:   sel = FIELD_REG_I;
         ODO_LOC_EA:      sel = EA_REG_I;
         ODO_LOC_IMPLIED: sel = IMPL_REG_I;
         default:         sel = FIELD_REG_I;
      endcase
   end

   // Implied byte, word and long sizes must be in the allowed subset; address regs refuse byte and bit
   always_comb begin
      size_ok = 1'b1;
      if (!SIZE_EXPLICIT_I && SIZE_I != ODO_SZ_BIT) begin
         size_ok = SIZE_ALLOWED_I[SIZE_I];
      end
      if (IS_ADDR_I && (SIZE_I == ODO_SZ_BYTE || SIZE_I == ODO_SZ_BIT)) begin
         size_ok = 1'b0;
      end
   end

   assign rd_raw = IS_ADDR_I ? areg[sel] : dreg[sel];

   always_comb begin
      for (int i = 0; i < ODO_NUM_DREG; i++) begin
         next_dreg[i] = dreg[i];
      end
      for (int i = 0; i < ODO_NUM_AREG; i++) begin
         next_areg[i] = areg[i];
      end
      if (WR_I && size_ok) begin
         if (IS_ADDR_I) begin
            // Whole register written; word source sign-extended
            next_areg[sel] = (SIZE_I == ODO_SZ_WORD)
                             ? {{16{WDATA_I[15]}}, WDATA_I[15:0]} : WDATA_I;
         end else if (SIZE_I == ODO_SZ_BIT) begin
            // Bit 0 is the LSB, bit 31 the MSB
            next_dreg[sel][BIT_NUM_I] = WDATA_I[0];
         end else begin
            // Only the sized low portion changes
            next_dreg[sel] = odo_merge(dreg[sel], WDATA_I, SIZE_I);
         end
      end
   end

   always_comb begin
      next_serr  = !size_ok;
      next_rbit  = dreg[sel][BIT_NUM_I];
      next_rdata = '0;
      if (size_ok) begin
         if (IS_ADDR_I) begin
            next_rdata = odo_trim(rd_raw, SIZE_I);
         end else if (SIZE_I == ODO_SZ_BIT) begin
            next_rdata = {31'h0000_0000, rd_raw[BIT_NUM_I]};
         end else begin
            next_rdata = odo_trim(rd_raw, SIZE_I);
         end
      end
   end

   // Two digits per byte, most significant in the upper nibble
   always_comb begin
      next_bcd = {4'((BCD_BIN_I / 8'd10) % 8'd10), 4'(BCD_BIN_I % 8'd10)};
   end

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         for (int i = 0; i < ODO_NUM_DREG; i++) begin
            dreg[i] <= ODO_REG_RESET;
         end
         for (int i = 0; i < ODO_NUM_AREG; i++) begin
            areg[i] <= ODO_REG_RESET;
         end
         rdata <= ODO_REG_RESET;
         rbit  <= 1'b0;
         serr  <= 1'b0;
         bcd   <= 8'h00;
      end else begin
         for (int i = 0; i < ODO_NUM_DREG; i++) begin
            dreg[i] <= next_dreg[i];
         end
         for (int i = 0; i < ODO_NUM_AREG; i++) begin
            areg[i] <= next_areg[i];
         end
         rdata <= next_rdata;
         rbit  <= next_rbit;
         serr  <= next_serr;
         bcd   <= next_bcd;
      end
   end

   assign RDATA_O    = rdata;
   assign RBIT_O     = rbit;
   assign SIZE_ERR_O = serr;
   assign BCD_PACK_O = bcd;
   assign BCD_HI_O   = bcd[7:4];
   assign BCD_LO_O   = bcd[3:0];

   // Memory side takes the selected register as store data
   odo_mem_port u_mem (
      .clk_i       (CLK_I),
      .rst_i       (RST_I),
      .req_i       (MREQ_I),
      .we_i        (MWE_I),
      .size_i      (SIZE_I),
      .addr_i      (MADDR_I),
      .wdata_i     (rd_raw),
      .busy_o      (MBUSY_O),
      .done_o      (MDONE_O),
      .align_err_o (MALIGN_ERR_O),
      .rdata_o     (MRDATA_O),
      .mem_req_o   (MEM_REQ_O),
      .mem_we_o    (MEM_WE_O),
      .mem_addr_o  (MEM_ADDR_O),
      .mem_be_o    (MEM_BE_O),
      .mem_wdata_o (MEM_WDATA_O),
      .mem_rdata_i (MEM_RDATA_I)
   );

   sequence s_dwrite_byte;
      WR_I && size_ok && !IS_ADDR_I && SIZE_I == ODO_SZ_BYTE;
   endsequence

   AST_DREG_UPPER_KEPT: assert property (@(posedge CLK_I) disable iff (RST_I)
      s_dwrite_byte |=> dreg[$past(sel)][31:8] == $past(dreg[sel][31:8]))
      else $error("byte write changed upper data register bits");
   AST_DREG_BYTE_LOW: assert property (@(posedge CLK_I) disable iff (RST_I)
      s_dwrite_byte |=> dreg[$past(sel)][7:0] == $past(WDATA_I[7:0]))
      else $error("byte write not in low 8 bits");
   AST_AREG_NO_BYTE: assert property (@(posedge CLK_I) disable iff (RST_I)
      IS_ADDR_I && SIZE_I == ODO_SZ_BYTE |=> SIZE_ERR_O && RDATA_O == 32'h0)
      else $error("byte size accepted on address register");
   AST_AREG_SEXT: assert property (@(posedge CLK_I) disable iff (RST_I)
      WR_I && size_ok && IS_ADDR_I && SIZE_I == ODO_SZ_WORD
      |=> areg[$past(sel)] == {{16{$past(WDATA_I[15])}}, $past(WDATA_I[15:0])})
      else $error("word write to address register not sign-extended");
   AST_AREG_WORD_SRC: assert property (@(posedge CLK_I) disable iff (RST_I)
      !WR_I && IS_ADDR_I && SIZE_I == ODO_SZ_WORD |=> RDATA_O[31:16] == 16'h0)
      else $error("word read of address register used upper bits");
   AST_BCD_PACK: assert property (@(posedge CLK_I) disable iff (RST_I)
      BCD_BIN_I < 8'd100 |=> BCD_HI_O * 10 + BCD_LO_O == $past(BCD_BIN_I))
      else $error("packed decimal digits misplaced");
   AST_BIT_READ: assert property (@(posedge CLK_I) disable iff (RST_I)
      !WR_I && !IS_ADDR_I && SIZE_I == ODO_SZ_BIT
      |=> RDATA_O == {31'h0, $past(dreg[sel][BIT_NUM_I])})
      else $error("bit read wrong position");
   AST_SIZE_SUBSET: assert property (@(posedge CLK_I) disable iff (RST_I)
      !SIZE_EXPLICIT_I && !IS_ADDR_I && SIZE_I != ODO_SZ_BIT && !SIZE_ALLOWED_I[SIZE_I]
      |=> SIZE_ERR_O)
      else $error("implied size outside subset accepted");
endmodule : odo_core

// File: verif/odo_mem_model.sv
// Word-organized memory model on the far side of the memory port
`timescale 1ns/1ps
module odo_mem_model
   import odo_pkg::*;
(
   // Clock
   input  wire logic                  clk_i,
   // Word access
   input  wire logic                  mem_req_i,
   input  wire logic                  mem_we_i,
   input  wire logic [ODO_ADDR_W-1:0] mem_addr_i,
   input  wire logic [1:0]            mem_be_i,
   input  wire logic [15:0]           mem_wdata_i,
   output logic [15:0]                mem_rdata_o
);
   logic [15:0] mem [0:255];
   wire  [7:0]  idx = mem_addr_i[8:1];

   initial begin
      for (int i = 0; i < 256; i++) begin
         mem[i] = 16'h0000;
      end
   end

   // Even byte is the high lane, odd byte the low lane
   always @(posedge clk_i) begin
      if (mem_req_i && mem_we_i) begin
         if (mem_be_i[1]) mem[idx][15:8] <= mem_wdata_i[15:8];
         if (mem_be_i[0]) mem[idx][7:0]  <= mem_wdata_i[7:0];
      end
   end

   // The port samples read data in the request cycle, so answer at once;
   // outside a read the bus shows junk, not a held value
   assign mem_rdata_o = (mem_req_i && !mem_we_i) ? mem[idx] : ~mem[idx];
endmodule : odo_mem_model

// File: verif/tb_top.sv
// Self-checking testbench for the operand data organization core
`timescale 1ns/1ps
module tb_top
   import odo_pkg::*;
;
   logic CLK_I, RST_I, SIZE_EXPLICIT_I, IS_ADDR_I, WR_I, MREQ_I, MWE_I;
   logic RBIT_O, SIZE_ERR_O, MBUSY_O, MDONE_O, MALIGN_ERR_O, MEM_REQ_O, MEM_WE_O;
   odo_size_t SIZE_I;
   odo_loc_t  LOC_I;
   logic [2:0]  SIZE_ALLOWED_I, FIELD_REG_I, EA_REG_I, IMPL_REG_I;
   logic [4:0]  BIT_NUM_I;
   logic [31:0] WDATA_I, RDATA_O, MRDATA_O;
   logic [7:0]  BCD_BIN_I, BCD_PACK_O;
   logic [3:0]  BCD_HI_O, BCD_LO_O;
   logic [23:0] MADDR_I, MEM_ADDR_O;
   logic [1:0]  MEM_BE_O;
   logic [15:0] MEM_WDATA_O, MEM_RDATA_I;
   int failures = 0;
   int check_count = 0;

   odo_core dut_u (.CLK_I(CLK_I), .RST_I(RST_I), .SIZE_I(SIZE_I),
      .SIZE_EXPLICIT_I(SIZE_EXPLICIT_I), .SIZE_ALLOWED_I(SIZE_ALLOWED_I), .LOC_I(LOC_I),
      .FIELD_REG_I(FIELD_REG_I), .EA_REG_I(EA_REG_I), .IMPL_REG_I(IMPL_REG_I),
      .IS_ADDR_I(IS_ADDR_I), .BIT_NUM_I(BIT_NUM_I), .WR_I(WR_I), .WDATA_I(WDATA_I),
      .RDATA_O(RDATA_O), .RBIT_O(RBIT_O), .SIZE_ERR_O(SIZE_ERR_O), .BCD_BIN_I(BCD_BIN_I),
      .BCD_PACK_O(BCD_PACK_O), .BCD_HI_O(BCD_HI_O), .BCD_LO_O(BCD_LO_O), .MREQ_I(MREQ_I),
      .MWE_I(MWE_I), .MADDR_I(MADDR_I), .MBUSY_O(MBUSY_O), .MDONE_O(MDONE_O),
      .MALIGN_ERR_O(MALIGN_ERR_O), .MRDATA_O(MRDATA_O), .MEM_REQ_O(MEM_REQ_O),
      .MEM_WE_O(MEM_WE_O), .MEM_ADDR_O(MEM_ADDR_O), .MEM_BE_O(MEM_BE_O),
      .MEM_WDATA_O(MEM_WDATA_O), .MEM_RDATA_I(MEM_RDATA_I));

   odo_mem_model mem_u (.clk_i(CLK_I), .mem_req_i(MEM_REQ_O), .mem_we_i(MEM_WE_O),
      .mem_addr_i(MEM_ADDR_O), .mem_be_i(MEM_BE_O), .mem_wdata_i(MEM_WDATA_O),
      .mem_rdata_o(MEM_RDATA_I));

   initial begin
      CLK_I = 1'b0;
      forever #5 CLK_I = ~CLK_I;
   end

   task automatic check_data(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check_data

   task automatic check_flag(input logic got, input logic exp);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check_flag

   task automatic finish_test();
      $display("failures=%0d check_count=%0d", failures, check_count);
      if (failures == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : finish_test

   // One register access; the unselected number fields point elsewhere
   task automatic acc(input odo_loc_t loc, input logic isa, input logic [2:0] idx,
                      input odo_size_t sz, input logic wr, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      LOC_I = loc;
      IS_ADDR_I = isa;
      SIZE_I = sz;
      WR_I = wr;
      WDATA_I = wd;
      FIELD_REG_I = (loc == ODO_LOC_FIELD) ? idx : ~idx;
      EA_REG_I = (loc == ODO_LOC_EA) ? idx : ~idx;
      IMPL_REG_I = (loc == ODO_LOC_IMPLIED) ? idx : ~idx;
      @(negedge CLK_I);
      rd = RDATA_O;
      err = SIZE_ERR_O;
   endtask : acc

   task automatic put(input logic isa, input logic [2:0] idx, input odo_size_t sz,
                      input logic [31:0] d, input logic err_exp);
      logic [31:0] rd;
      logic        err;
      acc(ODO_LOC_FIELD, isa, idx, sz, 1'b1, d, rd, err);
      check_flag(err, err_exp);
   endtask : put

   task automatic get(input odo_loc_t loc, input logic isa, input logic [2:0] idx,
                      input odo_size_t sz, input logic [31:0] exp);
      logic [31:0] rd;
      logic        err;
      acc(loc, isa, idx, sz, 1'b0, 32'h0, rd, err);
      check_data(rd, exp);
      check_flag(err, 1'b0);
   endtask : get

   task automatic t_data();
      logic [31:0] rd;
      logic        err;
      put(1'b0, 3'h2, ODO_SZ_LONG, 32'h89ab_cdef, 1'b0);
      put(1'b0, 3'h2, ODO_SZ_BYTE, 32'hffff_ff5a, 1'b0);
      get(ODO_LOC_FIELD, 1'b0, 3'h2, ODO_SZ_LONG, 32'h89ab_cd5a);
      put(1'b0, 3'h2, ODO_SZ_WORD, 32'hffff_1234, 1'b0);
      get(ODO_LOC_FIELD, 1'b0, 3'h2, ODO_SZ_LONG, 32'h89ab_1234);
      get(ODO_LOC_FIELD, 1'b0, 3'h2, ODO_SZ_WORD, 32'h0000_1234);
      get(ODO_LOC_FIELD, 1'b0, 3'h2, ODO_SZ_BYTE, 32'h0000_0034);
      for (int i = 0; i < 32; i++) begin
         BIT_NUM_I = 5'(i);
         acc(ODO_LOC_FIELD, 1'b0, 3'h2, ODO_SZ_BIT, 1'b0, 32'h0, rd, err);
         check_flag(RBIT_O, 1'(32'h89ab_1234 >> i));
      end
   endtask : t_data

   task automatic t_addr();
      logic [31:0] rd;
      logic        err;
      put(1'b1, 3'h3, ODO_SZ_LONG, 32'h1234_5678, 1'b0);
      put(1'b1, 3'h3, ODO_SZ_BYTE, 32'h0000_00aa, 1'b1);
      get(ODO_LOC_FIELD, 1'b1, 3'h3, ODO_SZ_LONG, 32'h1234_5678);
      put(1'b1, 3'h3, ODO_SZ_WORD, 32'h0000_8001, 1'b0);
      get(ODO_LOC_FIELD, 1'b1, 3'h3, ODO_SZ_LONG, 32'hffff_8001);
      get(ODO_LOC_FIELD, 1'b1, 3'h3, ODO_SZ_WORD, 32'h0000_8001);
      put(1'b1, 3'h3, ODO_SZ_WORD, 32'hffff_7ffe, 1'b0);
      get(ODO_LOC_FIELD, 1'b1, 3'h3, ODO_SZ_LONG, 32'h0000_7ffe);
      acc(ODO_LOC_FIELD, 1'b1, 3'h3, ODO_SZ_BYTE, 1'b0, 32'h0, rd, err);
      check_flag(err, 1'b1);
      check_data(rd, 32'h0);
      put(1'b1, 3'h7, ODO_SZ_LONG, 32'h00fe_dcb8, 1'b0);
      get(ODO_LOC_FIELD, 1'b1, 3'h7, ODO_SZ_LONG, 32'h00fe_dcb8);
   endtask : t_addr

   task automatic t_loc_size();
      put(1'b0, 3'h5, ODO_SZ_LONG, 32'h0bad_f00d, 1'b0);
      get(ODO_LOC_EA, 1'b0, 3'h5, ODO_SZ_LONG, 32'h0bad_f00d);
      get(ODO_LOC_IMPLIED, 1'b0, 3'h5, ODO_SZ_LONG, 32'h0bad_f00d);
      SIZE_EXPLICIT_I = 1'b0;
      SIZE_ALLOWED_I = 3'b010;
      put(1'b0, 3'h5, ODO_SZ_BYTE, 32'h0000_0077, 1'b1);
      put(1'b0, 3'h5, ODO_SZ_WORD, 32'h0000_1111, 1'b0);
      SIZE_ALLOWED_I = 3'b101;
      put(1'b0, 3'h5, ODO_SZ_WORD, 32'h0000_2222, 1'b1);
      SIZE_EXPLICIT_I = 1'b1;
      get(ODO_LOC_FIELD, 1'b0, 3'h5, ODO_SZ_LONG, 32'h0bad_1111);
      put(1'b0, 3'h5, ODO_SZ_WORD, 32'h0000_2222, 1'b0);
      put(1'b0, 3'h5, ODO_SZ_BYTE, 32'h0000_0033, 1'b0);
      get(ODO_LOC_FIELD, 1'b0, 3'h5, ODO_SZ_LONG, 32'h0bad_2233);
   endtask : t_loc_size

   task automatic t_bcd();
      int v [7] = '{0, 9, 10, 45, 99, 100, 255};
      int m;
      for (int i = 0; i < 7; i++) begin
         m = v[i] % 100;
         BCD_BIN_I = 8'(v[i]);
         @(negedge CLK_I);
         check_data({24'h0, BCD_PACK_O}, 32'((m / 10) * 16 + m % 10));
         check_data({24'h0, BCD_HI_O, BCD_LO_O}, 32'((m / 10) * 16 + m % 10));
      end
   endtask : t_bcd

   task automatic mop(input logic we, input odo_size_t sz, input logic [23:0] a,
                      input int n_exp, input logic err_exp);
      int n;
      n = 0;
      WR_I = 1'b0;
      @(negedge CLK_I);
      MREQ_I = 1'b1;
      MWE_I = we;
      MADDR_I = a;
      SIZE_I = sz;
      do begin
         @(negedge CLK_I);
         MREQ_I = 1'b0;
         n++;
         if (n == 1) check_flag(MBUSY_O, !err_exp);
      end while (n < 20 && MDONE_O !== 1'b1);
      check_data(32'(n), 32'(n_exp));
      check_flag(MALIGN_ERR_O, err_exp);
   endtask : mop

   task automatic t_mem();
      put(1'b0, 3'h6, ODO_SZ_LONG, 32'h1357_9bdf, 1'b0);
      mop(1'b1, ODO_SZ_LONG, 24'h000100, 3, 1'b0);
      check_data({16'h0, mem_u.mem[8'h80]}, 32'h1357);
      check_data({16'h0, mem_u.mem[8'h81]}, 32'h9bdf);
      mop(1'b0, ODO_SZ_LONG, 24'h000100, 3, 1'b0);
      check_data(MRDATA_O, 32'h1357_9bdf);
      mop(1'b1, ODO_SZ_WORD, 24'h000104, 2, 1'b0);
      put(1'b0, 3'h6, ODO_SZ_BYTE, 32'h0000_0021, 1'b0);
      mop(1'b1, ODO_SZ_BYTE, 24'h000105, 2, 1'b0);
      check_data({16'h0, mem_u.mem[8'h82]}, 32'h9b21);
      mop(1'b0, ODO_SZ_BYTE, 24'h000104, 2, 1'b0);
      check_data(MRDATA_O, 32'h0000_009b);
      mop(1'b0, ODO_SZ_BYTE, 24'h000105, 2, 1'b0);
      check_data(MRDATA_O, 32'h0000_0021);
      mop(1'b0, ODO_SZ_WORD, 24'h000103, 1, 1'b1);
      mop(1'b1, ODO_SZ_LONG, 24'h000101, 1, 1'b1);
      check_data({16'h0, mem_u.mem[8'h80]}, 32'h1357);
   endtask : t_mem

   // Every word access on the memory side must sit on a word boundary
   always @(posedge CLK_I) begin
      if (MEM_REQ_O === 1'b1) check_flag(MEM_ADDR_O[0], 1'b0);
   end

   initial begin
      repeat (5000) @(posedge CLK_I);
      failures++;
      finish_test();
   end

   initial begin
      RST_I = 1'b1;
      SIZE_I = ODO_SZ_LONG;
      SIZE_EXPLICIT_I = 1'b1;
      SIZE_ALLOWED_I = 3'b111;
      LOC_I = ODO_LOC_FIELD;
      {FIELD_REG_I, EA_REG_I, IMPL_REG_I} = 9'h000;
      {IS_ADDR_I, WR_I, MREQ_I, MWE_I} = 4'h0;
      BIT_NUM_I = 5'h00;
      WDATA_I = 32'h0;
      BCD_BIN_I = 8'h00;
      MADDR_I = 24'h0;
      repeat (6) @(negedge CLK_I);
      RST_I = 1'b0;
      @(negedge CLK_I);
      t_data();
      t_addr();
      t_loc_size();
      t_bcd();
      t_mem();
      finish_test();
   end
endmodule : tb_top
